// ### shared/pwpm_defines.vh
// Constants for the pulse width / period meter: register offsets,
// field positions, reset values and timebase divider counts.
// Included by bare name from the meter design file, the checker and the bench.
`ifndef PWPM_DEFINES_VH
`define PWPM_DEFINES_VH

// Register offsets (byte addresses on the 5-bit register port)
`define PWPM_OFS_CONFIG 5'h00
`define PWPM_OFS_COMMAND 5'h04
`define PWPM_OFS_STATUS 5'h08
`define PWPM_OFS_COUNT 5'h0C
`define PWPM_OFS_HANDLE 5'h10

// Configuration fields
`define PWPM_CFG_MSEL_LSB 0
`define PWPM_CFG_MSEL_MSB 1
`define PWPM_CFG_TBSEL_BIT 2
`define PWPM_CFG_RATE_LSB 3
`define PWPM_CFG_RATE_MSB 5
`define PWPM_CONFIG_RESET 6'h00

// Measurement select codes
`define PWPM_MODE_HIGH_WIDTH 2'h0
`define PWPM_MODE_LOW_WIDTH 2'h1
`define PWPM_MODE_RISING_PERIOD 2'h2
`define PWPM_MODE_FALLING_PERIOD 2'h3

// Command fields
`define PWPM_CMD_ARM_BIT 0
`define PWPM_CMD_HALT_BIT 1
`define PWPM_CMD_FETCH_BIT 2
`define PWPM_CMD_HANDLE_LSB 8
`define PWPM_CMD_HANDLE_MSB 15

// Status fields
`define PWPM_ST_CONFIGURED_BIT 0
`define PWPM_ST_ARMED_BIT 1
`define PWPM_ST_COUNTING_BIT 2
`define PWPM_ST_DONE_BIT 3
`define PWPM_ST_OVERFLOW_BIT 4
`define PWPM_ST_REJECT_BIT 5
`define PWPM_ST_HANDLE_LSB 8
`define PWPM_ST_HANDLE_MSB 15

// Internal timebase: supported rate codes and their divide counts at 125 MHz
`define PWPM_RATE_LAST_VALID 3'h4
`define PWPM_DIV_RATE0 16'h0001
`define PWPM_DIV_RATE1 16'h0008
`define PWPM_DIV_RATE2 16'h007D
`define PWPM_DIV_RATE3 16'h04E2
`define PWPM_DIV_RATE4_DEFAULT 16'h30D4

`define PWPM_HANDLE_RESET 8'h00
`define PWPM_COUNT_RESET 32'h00000000

`endif

// ### hdl/pwpm_edge_sync.v
// Two-flop synchroniser with rising and falling edge pulses.
// Assumes an asynchronous pin input and the block clock mclk.
`timescale 1ns/10ps

module pwpm_edge_sync
(
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Pin side
    input wire pin_in,
    // Synchronised side
    output wire level_out,
    output wire rise_pulse,
    output wire fall_pulse
);

reg meta_reg;
reg sync_reg;
reg prev_reg;

// The first stage feeds only the second; edges are taken from later stages
always @(posedge mclk or negedge rst_n)
begin
    if (!rst_n)
    begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
        prev_reg <= 1'b0;
    end
    else
    begin
        meta_reg <= pin_in;
        sync_reg <= meta_reg;
        prev_reg <= sync_reg;
    end
end

assign level_out = sync_reg;
assign rise_pulse = sync_reg & ~prev_reg;
assign fall_pulse = ~sync_reg & prev_reg;

endmodule // pwpm_edge_sync

// ### hdl/pwpm_meter.v
// Pulse width and period meter: counts timebase ticks between a start
// edge and an end edge of the measured gate input.
// Assumes one 125 MHz clock, asynchronous pins, and a register master that
// issues one-cycle read or write strobes and takes read data a cycle later.
`timescale 1ns/10ps
`include "pwpm_defines.vh"

module pwpm_meter
#(
    // Divide count of the slowest internal rate; shorten for simulation
    parameter [15:0] RATE4_DIV = `PWPM_DIV_RATE4_DEFAULT
)
(
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Measured signal and external timebase pins
    input wire gate_in,
    input wire source_in,
    // Register port
    input wire [4:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Status pins
    output reg meas_done,
    output reg count_overflow
);

localparam [2:0] ST_FREE = 3'h0;
localparam [2:0] ST_READY = 3'h1;
localparam [2:0] ST_WAIT_START = 3'h2;
localparam [2:0] ST_COUNTING = 3'h3;
localparam [2:0] ST_DONE = 3'h4;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

wire gate_rise;
wire gate_fall;
wire source_rise;

pwpm_edge_sync u_gate_sync
(
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_in(gate_in),
    .level_out(),
    .rise_pulse(gate_rise),
    .fall_pulse(gate_fall)
);

pwpm_edge_sync u_source_sync
(
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_in(source_in),
    .level_out(),
    .rise_pulse(source_rise),
    .fall_pulse()
);

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [2:0] state_reg;
reg [2:0] state_next;
reg [1:0] measurement_select_reg;
reg timebase_select_reg;
reg [2:0] rate_reg;
reg [7:0] counter_handle_reg;
reg [7:0] handle_seed_reg;
reg [31:0] count_reg;
reg [31:0] result_reg;
reg reject_reg;
reg [15:0] div_cnt_reg;
reg [15:0] div_limit;
reg tick;
reg start_edge;
reg end_edge;

wire wr_config = reg_wr && (reg_addr == `PWPM_OFS_CONFIG);
wire wr_command = reg_wr && (reg_addr == `PWPM_OFS_COMMAND);
wire [2:0] new_rate = reg_wdata[`PWPM_CFG_RATE_MSB:`PWPM_CFG_RATE_LSB];
wire new_ext = reg_wdata[`PWPM_CFG_TBSEL_BIT];
// A rate code outside the supported set is refused when internal is chosen
wire rate_ok = new_ext || (new_rate <= `PWPM_RATE_LAST_VALID);
// Reconfiguring is only allowed on a free counter; halt releases it first
wire config_accept = wr_config && (state_reg == ST_FREE) && rate_ok;
wire handle_match = (reg_wdata[`PWPM_CMD_HANDLE_MSB:`PWPM_CMD_HANDLE_LSB] == counter_handle_reg)
    && (state_reg != ST_FREE);
wire cmd_arm = wr_command && handle_match && reg_wdata[`PWPM_CMD_ARM_BIT];
wire cmd_halt = wr_command && handle_match && reg_wdata[`PWPM_CMD_HALT_BIT];
wire cmd_fetch = wr_command && handle_match && reg_wdata[`PWPM_CMD_FETCH_BIT];
wire counting = (state_reg == ST_COUNTING);
wire wrap = counting && tick && (count_reg == 32'hFFFFFFFF);

////////////////////////////////////////////////////////////////////////////////
// Timebase selection

always @*
begin
    case (rate_reg)
        3'h0: div_limit = `PWPM_DIV_RATE0;
        3'h1: div_limit = `PWPM_DIV_RATE1;
        3'h2: div_limit = `PWPM_DIV_RATE2;
        3'h3: div_limit = `PWPM_DIV_RATE3;
        default: div_limit = RATE4_DIV;
    endcase
end

// The divider runs only while counting so each interval starts phase-aligned
always @(posedge mclk or negedge rst_n)
begin
    if (!rst_n)
        div_cnt_reg <= 16'h0000;
    else if (!counting || (div_cnt_reg >= div_limit - 16'h0001))
        div_cnt_reg <= 16'h0000;
    else
        div_cnt_reg <= div_cnt_reg + 16'h0001;
end

always @*
begin
    if (timebase_select_reg)
        tick = source_rise;
    else
        tick = counting && (div_cnt_reg >= div_limit - 16'h0001);
end

////////////////////////////////////////////////////////////////////////////////
// Start and end events per measurement mode

always @*
begin
    case (measurement_select_reg)
        `PWPM_MODE_HIGH_WIDTH:
        begin
            start_edge = gate_rise;
            end_edge = gate_fall;
        end
        `PWPM_MODE_LOW_WIDTH:
        begin
            start_edge = gate_fall;
            end_edge = gate_rise;
        end
        `PWPM_MODE_RISING_PERIOD:
        begin
            start_edge = gate_rise;
            end_edge = gate_rise;
        end
        default:
        begin
            start_edge = gate_fall;
            end_edge = gate_fall;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Measurement sequencer

always @*
begin
    state_next = state_reg;
    case (state_reg)
        ST_FREE:
        begin
            if (config_accept)
                state_next = ST_READY;
        end
        ST_READY, ST_DONE:
        begin
            if (cmd_halt)
                state_next = ST_FREE;
            else if (cmd_arm)
                state_next = ST_WAIT_START;
        end
        ST_WAIT_START:
        begin
            if (cmd_halt)
                state_next = ST_FREE;
            else if (start_edge)
                state_next = ST_COUNTING;
        end
        ST_COUNTING:
        begin
            if (cmd_halt)
                state_next = ST_FREE;
            else if (cmd_arm)
                state_next = ST_WAIT_START;
            else if (end_edge)
                state_next = ST_DONE;
        end
        default:
            state_next = ST_FREE;
    endcase
end

always @(posedge mclk or negedge rst_n)
begin
    if (!rst_n)
        state_reg <= ST_FREE;
    else
        state_reg <= state_next;
end

// Configuration and handle allocation
always @(posedge mclk or negedge rst_n)
begin
    if (!rst_n)
    begin
        measurement_select_reg <= `PWPM_MODE_HIGH_WIDTH;
        timebase_select_reg <= 1'b0;
        rate_reg <= 3'h0;
        counter_handle_reg <= `PWPM_HANDLE_RESET;
        handle_seed_reg <= `PWPM_HANDLE_RESET;
        reject_reg <= 1'b0;
    end
    else
    begin
        if (config_accept)
        begin
            measurement_select_reg <= reg_wdata[`PWPM_CFG_MSEL_MSB:`PWPM_CFG_MSEL_LSB];
            timebase_select_reg <= new_ext;
            rate_reg <= new_rate;
            // Skip zero so a released counter never matches a live handle
            if (handle_seed_reg == 8'hFF)
            begin
                counter_handle_reg <= 8'h01;
                handle_seed_reg <= 8'h01;
            end
            else
            begin
                counter_handle_reg <= handle_seed_reg + 8'h01;
                handle_seed_reg <= handle_seed_reg + 8'h01;
            end
        end
        else if (cmd_halt)
            counter_handle_reg <= `PWPM_HANDLE_RESET;
        if (wr_config)
            reject_reg <= !config_accept;
    end
end

// Count, overflow and fetched result
always @(posedge mclk or negedge rst_n)
begin
    if (!rst_n)
    begin
        count_reg <= `PWPM_COUNT_RESET;
        result_reg <= `PWPM_COUNT_RESET;
        count_overflow <= 1'b0;
        meas_done <= 1'b0;
    end
    else
    begin
        if (cmd_arm)
            count_reg <= `PWPM_COUNT_RESET;
        else if (counting && tick)
            count_reg <= count_reg + 32'h00000001;
        // A wrap in the arm cycle still sets the flag: set wins over clear
        count_overflow <= wrap | (count_overflow & ~cmd_arm);
        meas_done <= (state_next == ST_DONE);
        if (cmd_fetch)
            result_reg <= count_reg;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register read port

always @(posedge mclk or negedge rst_n)
begin
    if (!rst_n)
        reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
        case (reg_addr)
            `PWPM_OFS_CONFIG:
                reg_rdata <= {26'h0000000, rate_reg, timebase_select_reg,
                    measurement_select_reg};
            `PWPM_OFS_STATUS:
                reg_rdata <= {16'h0000, counter_handle_reg, 2'h0, reject_reg,
                    count_overflow, (state_reg == ST_DONE), counting,
                    (state_reg == ST_WAIT_START), (state_reg != ST_FREE)};
            `PWPM_OFS_COUNT:
                reg_rdata <= result_reg;
            `PWPM_OFS_HANDLE:
                reg_rdata <= {24'h000000, counter_handle_reg};
            default:
                reg_rdata <= 32'h00000000;
        endcase
    end
    else
        reg_rdata <= 32'h00000000;
end

endmodule // pwpm_meter

// ### dv/pwpm_checker.sv
// Port assertions for the pulse width / period meter.
// Bound to pwpm_meter from tb_top; one clock, async active-low reset.
`timescale 1ns/10ps
`include "pwpm_defines.vh"
module pwpm_checker
(
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Pins
    input wire gate_in,
    input wire source_in,
    // Register port
    input wire [4:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // Status
    input wire meas_done,
    input wire count_overflow
);
    reg g_reg;
    reg [3:0] age_reg;
    reg [1:0] mode_reg;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Age of the last gate change, saturating so it never wraps to a false match
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            g_reg <= 1'b0;
            age_reg <= 4'hF;
            mode_reg <= 2'h0;
        end
        else
        begin
            g_reg <= gate_in;
            age_reg <= (gate_in != g_reg) ? 4'h0 : ((age_reg == 4'hF) ? age_reg : age_reg + 4'h1);
            if (reg_wr && reg_addr == `PWPM_OFS_CONFIG)
                mode_reg <= reg_wdata[1:0];
        end
    end
    ////////////////////////////////////////////////////////////
    property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped; reg_rd && reg_addr > 5'h10 |=> reg_rdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_st_mirror;
        reg_rd && reg_addr == `PWPM_OFS_STATUS |=>
            reg_rdata[4:3] == $past({count_overflow, meas_done});
    endproperty
    a_st_mirror: assert property (p_st_mirror) else $error("status bits");
    property p_done_hold; meas_done && !reg_wr |=> meas_done; endproperty
    a_done_hold: assert property (p_done_hold) else $error("done lost");
    property p_done_fall; $fell(meas_done) |-> $past(reg_wr); endproperty
    a_done_fall: assert property (p_done_fall) else $error("done fell alone");
    property p_ovf_fall; $fell(count_overflow) |-> $past(reg_wr); endproperty
    a_ovf_fall: assert property (p_ovf_fall) else $error("overflow not sticky");
    property p_done_edge; $rose(meas_done) |-> age_reg >= 4'h1 && age_reg <= 4'h4; endproperty
    a_done_edge: assert property (p_done_edge) else $error("done without edge");
    property p_done_lvl;
        $rose(meas_done) |-> gate_in == (mode_reg == 2'h1 || mode_reg == 2'h2);
    endproperty
    a_done_lvl: assert property (p_done_lvl) else $error("wrong end edge");
endmodule // pwpm_checker

// ### dv/pwpm_sig_gen.sv
// Far-side model: measured gate signal and external timebase.
// Assumes the bench sets widths before raising run.
`timescale 1ns/10ps
module pwpm_sig_gen
(
    // Clock
    input wire mclk,
    // Bench control
    input wire run,
    input wire [7:0] hi_cyc,
    input wire [7:0] lo_cyc,
    input wire [3:0] src_half,
    // Meter pins
    output reg gate_in,
    output reg source_in
);
    reg [8:0] ph_reg = 9'h000;
    reg [3:0] sc_reg = 4'h0;
    initial gate_in = 1'b0;
    initial source_in = 1'b0;
    // Pins move 1 ns after the edge so counts are exact, not phase dependent
    always @(posedge mclk)
    begin
        if (!run)
        begin
            ph_reg <= 9'h000;
            sc_reg <= 4'h0;
            gate_in <= #1 1'b0;
            source_in <= #1 1'b0;
        end
        else
        begin
            gate_in <= #1 (ph_reg < {1'b0, hi_cyc});
            ph_reg <= (ph_reg == {1'b0, hi_cyc} + {1'b0, lo_cyc} - 9'h001) ? 9'h000
                : ph_reg + 9'h001;
            sc_reg <= (sc_reg == src_half - 4'h1) ? 4'h0 : sc_reg + 4'h1;
            if (sc_reg == src_half - 4'h1)
                source_in <= #1 ~source_in;
        end
    end
endmodule // pwpm_sig_gen

// ### dv/tb_top.sv
// Queue-scoreboard bench for pwpm_meter with the signal generator.
// Assumes RATE4_DIV shortened to 4; read data checked one cycle after reg_rd.
`timescale 1ns/10ps
`include "pwpm_defines.vh"
module tb_top;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg [4:0] reg_addr = 5'h00;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg run = 1'b0;
    reg [7:0] hi_c = 8'h08;
    reg [7:0] lo_c = 8'h08;
    reg rd_seen = 1'b0;
    wire gate_in, source_in, meas_done, count_overflow;
    wire [31:0] reg_rdata;
    logic [31:0] exp_q[$];
    logic [31:0] tol_q[$];
    logic [31:0] me, mt;
    logic [7:0] hnd = 8'h00;
    integer n_fail = 0, cmp_count = 0, seed = 75956, i, k, n, h, l;
    always #4 mclk = ~mclk;
    pwpm_meter #(.RATE4_DIV(16'h0004)) dut_u (.mclk(mclk), .rst_n(rst_n), .gate_in(gate_in),
        .source_in(source_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_done(meas_done),
        .count_overflow(count_overflow));
    pwpm_sig_gen gen_u (.mclk(mclk), .run(run), .hi_cyc(hi_c), .lo_cyc(lo_c),
        .src_half(4'h2), .gate_in(gate_in), .source_in(source_in));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] t);
        exp_q.push_back(e);
        tol_q.push_back(t);
        reg_addr <= a;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic idle(input integer c);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (c) @(posedge mclk);
    endtask
    // Arm with a wrong handle first: it must leave the counter configured but unarmed
    task automatic meas(input logic [5:0] c, input integer ne, input integer t);
        hnd = hnd + 8'h01;
        wr(`PWPM_OFS_CONFIG, {26'h0, c});
        wr(`PWPM_OFS_COMMAND, {16'h0, hnd + 8'h01, 8'h01});
        rd(`PWPM_OFS_STATUS, {16'h0, hnd, 8'h01}, 0);
        wr(`PWPM_OFS_COMMAND, {16'h0, hnd, 8'h01});
        idle(1);
        run <= 1'b1;
        n = 0;
        while (meas_done !== 1'b1 && n < 400)
        begin
            @(posedge mclk);
            n++;
        end
        chk({31'h0, meas_done}, 32'h1);
        // Widths of 8 and up keep every count above 3, the least a reader trusts
        chk({31'h0, count_overflow}, 32'h0);
        run <= 1'b0;
        wr(`PWPM_OFS_COMMAND, {16'h0, hnd, 8'h04});
        rd(`PWPM_OFS_COUNT, ne, t);
        rd(`PWPM_OFS_STATUS, {16'h0, hnd, 8'h09}, 0);
        wr(`PWPM_OFS_COMMAND, {16'h0, hnd, 8'h02});
        rd(`PWPM_OFS_HANDLE, 32'h0, 0);
        idle(3);
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge mclk)
    begin
        if (rd_seen)
        begin
            me = exp_q.pop_front();
            mt = tol_q.pop_front();
            chk((reg_rdata >= me - mt && reg_rdata <= me + mt) ? me : reg_rdata, me);
        end
        rd_seen <= reg_rd;
    end
    initial
    begin
        #400000;
        n_fail++;
        end_of_test;
    end
    initial
    begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(5'h14, 32'h0, 0);
        for (k = 0; k < 8; k++)
        begin
            wr(`PWPM_OFS_CONFIG, {26'h0, k[2:0], 3'h0});
            rd(`PWPM_OFS_STATUS, (k > 4) ? 32'h20 : {16'h0, hnd + 8'h01, 8'h01}, 0);
            if (k <= 4)
            begin
                hnd = hnd + 8'h01;
                wr(`PWPM_OFS_COMMAND, {16'h0, hnd, 8'h02});
            end
        end
        idle(3);
        $display("test rate codes done");
        for (i = 0; i < 4; i++)
        begin
            h = 8 + ($random(seed) & 31);
            l = 8 + ($random(seed) & 31);
            hi_c <= h[7:0];
            lo_c <= l[7:0];
            meas({4'h0, i[1:0]}, (i == 0) ? h : ((i == 1) ? l : h + l), 0);
            $display("test mode %0d done", i);
        end
        hi_c <= 8'h08;
        lo_c <= 8'h08;
        meas({3'h0, 1'b1, `PWPM_MODE_RISING_PERIOD}, 4, 1);
        $display("test external timebase done");
        // Slowest internal rate, shortened to divide by 4 in this bench
        hi_c <= 8'h10;
        lo_c <= 8'h10;
        meas({3'h4, 1'b0, `PWPM_MODE_HIGH_WIDTH}, 16 / 4, 0);
        $display("test divided timebase done");
        // Halt in mid-interval: nothing completes and the handle is released
        hnd = hnd + 8'h01;
        hi_c <= 8'h20;
        wr(`PWPM_OFS_CONFIG, 32'h00000020);
        rd(`PWPM_OFS_CONFIG, 32'h00000020, 0);
        wr(`PWPM_OFS_COMMAND, {16'h0, hnd, 8'h01});
        idle(1);
        run <= 1'b1;
        idle(10);
        rd(`PWPM_OFS_STATUS, {16'h0, hnd, 8'h05}, 0);
        wr(`PWPM_OFS_COMMAND, {16'h0, hnd, 8'h02});
        idle(40);
        chk({31'h0, meas_done}, 32'h0);
        rd(`PWPM_OFS_STATUS, 32'h0, 0);
        run <= 1'b0;
        idle(3);
        $display("test halt while counting done");
        end_of_test;
    end
endmodule // tb_top
bind pwpm_meter pwpm_checker chk_u (.mclk(mclk), .rst_n(rst_n), .gate_in(gate_in),
    .source_in(source_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_done(meas_done),
    .count_overflow(count_overflow));
